// ### rtl/input_signal_detect_ctrl.sv
// input signal-detect control: registers, step divider, eight channels,
// combined detect event and interrupt
// assumes: Avalon-MM slave with waitrequest, byte addresses on ADDRESS_I,
// sample stream from the digital volume stage on the same clock
`timescale 1ns/1ps
`include "sigdet_cfg.svh"
module input_signal_detect_ctrl #(
  parameter int SAMPLE_W    = 24,
  parameter int STEP_CYCLES = `SD_STEP_MS * `SD_CLK_KHZ
) (
  input  wire logic                    MCLK_I,
  input  wire logic                    RST_I,
  // register bus
  input  wire logic [11:0]             ADDRESS_I,
  input  wire logic                    READ_I,
  input  wire logic                    WRITE_I,
  input  wire logic [31:0]             WRITEDATA_I,
  input  wire logic [3:0]              BYTEENABLE_I,
  output logic      [31:0]             READDATA_O,
  output logic                         WAITREQUEST_O,
  // sample stream, channel 0 in the low bits
  input  wire logic                    SAMPLE_VALID_I,
  input  wire logic [8*SAMPLE_W-1:0]   SAMPLE_I,
  output logic                         SAMPLE_VALID_O,
  output logic      [8*SAMPLE_W-1:0]   SAMPLE_O,
  // detect state and interrupt
  output logic      [7:0]              DETECT_O,
  output logic                         IRQ_O
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam int STEP_W = $clog2(STEP_CYCLES);
  localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(STEP_CYCLES - 1);

  // channel order: path1 L, path1 R, path2 L ... path4 R
  localparam logic [9:0] CH_IDX [8] = '{
    `SD_REG_IN1L, `SD_REG_IN1R, `SD_REG_IN2L, `SD_REG_IN2R,
    `SD_REG_IN3L, `SD_REG_IN3R, `SD_REG_IN4L, `SD_REG_IN4R
  };

  logic [7:0]                 detect_enable;
  sigdet_pkg::thr_code_type   detect_threshold_level;
  sigdet_pkg::hold_code_type  detect_hold_time;
  logic                       irq_status;
  logic                       irq_mask;
  logic                       armed;

  logic [STEP_W-1:0]          step_cnt;
  logic                       step_tick;

  logic [7:0]                 detect;
  logic [7:0]                 above;
  logic [8*SAMPLE_W-1:0]      sample_out;

  logic [9:0]                 idx;
  logic                       req;
  logic                       done;
  logic                       wr;
  logic [15:0]                rd_value;
  sigdet_pkg::thr_code_type   next_thr;
  logic                       det_any;
  logic                       event_set;
  logic                       status_clear;

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  // word index; the two low address bits select nothing
  assign idx  = ADDRESS_I[11:2];
  assign req  = READ_I | WRITE_I;
  // the completing edge is the one where waitrequest is already low
  assign done = req & ~WAITREQUEST_O;
  assign wr   = WRITE_I & done;

  // one wait cycle per access, then release for one cycle
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      WAITREQUEST_O <= 1'b1;
    end else if (req && WAITREQUEST_O) begin
      WAITREQUEST_O <= 1'b0;
    end else begin
      WAITREQUEST_O <= 1'b1;
    end
  end

  // read data captured as waitrequest drops, stable at the taking edge
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      READDATA_O <= 32'h00000000;
    end else if (READ_I && WAITREQUEST_O) begin
      READDATA_O <= {16'h0000, rd_value};
    end
  end

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  // unmapped words and unused bits read as zero
  always_comb begin
    rd_value = 16'h0000;
    for (int c = 0; c < 8; c++) begin
      if (idx == CH_IDX[c]) begin
        rd_value[`SD_ENA_BIT] = detect_enable[c];
      end
    end
    case (idx)
      `SD_REG_GLOBAL: begin
        rd_value[`SD_THR_MSB:`SD_THR_LSB]   = detect_threshold_level;
        rd_value[`SD_HOLD_MSB:`SD_HOLD_LSB] = detect_hold_time;
      end
      `SD_REG_IRQ_STAT: begin
        rd_value[0] = irq_status;
      end
      `SD_REG_IRQ_MASK: begin
        rd_value[0] = irq_mask;
      end
      `SD_REG_STATUS: begin
        rd_value = {above, detect};
      end
      default: begin
        // channel words were decoded by the loop above
      end
    endcase
  end

  // ----------------------------------------------------------------
  // per-channel enable registers
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_ena
      // bit 15 lives in the upper byte lane
      always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
          detect_enable[g] <= 1'b0;
        end else if (wr && BYTEENABLE_I[1] && idx == CH_IDX[g]) begin
          detect_enable[g] <= WRITEDATA_I[`SD_ENA_BIT];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // shared threshold and hold settings
  // ----------------------------------------------------------------
  // threshold straddles both byte lanes; merge the lanes first
  always_comb begin
    next_thr = detect_threshold_level;
    if (BYTEENABLE_I[0]) begin
      next_thr[3:0] = WRITEDATA_I[`SD_THR_LSB+3:`SD_THR_LSB];
    end
    if (BYTEENABLE_I[1]) begin
      next_thr[4] = WRITEDATA_I[`SD_THR_MSB];
    end
  end

  // reserved codes are dropped so the detector never sees them
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      detect_threshold_level <= `SD_THR_RST;
    end else if (wr && idx == `SD_REG_GLOBAL &&
                 next_thr <= `SD_THR_MAX) begin
      detect_threshold_level <= next_thr;
    end
  end

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      detect_hold_time <= `SD_HOLD_RST;
    end else if (wr && idx == `SD_REG_GLOBAL && BYTEENABLE_I[0] &&
                 WRITEDATA_I[`SD_HOLD_MSB:`SD_HOLD_LSB] != `SD_HOLD_RSVD)
    begin
      detect_hold_time <=
        WRITEDATA_I[`SD_HOLD_MSB:`SD_HOLD_LSB];
    end
  end

  // ----------------------------------------------------------------
  // 4 ms step divider
  // ----------------------------------------------------------------
  // free-running, so a hold lasts between n and n+1 steps
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      step_cnt  <= '0;
      step_tick <= 1'b0;
    end else if (step_cnt == STEP_LAST) begin
      step_cnt  <= '0;
      step_tick <= 1'b1;
    end else begin
      step_cnt  <= step_cnt + 1'b1;
      step_tick <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------
  generate
    for (g = 0; g < 8; g++) begin : g_ch
      sigdet_channel #(
        .SAMPLE_W (SAMPLE_W)
      ) u_ch (
        .clk_i       (MCLK_I),
        .rst_i       (RST_I),
        .enable_i    (detect_enable[g]),
        .valid_i     (SAMPLE_VALID_I),
        .sample_i    (SAMPLE_I[g*SAMPLE_W +: SAMPLE_W]),
        .thr_code_i  (detect_threshold_level),
        .hold_code_i (detect_hold_time),
        .step_i      (step_tick),
        .sample_o    (sample_out[g*SAMPLE_W +: SAMPLE_W]),
        .detect_o    (detect[g]),
        .above_o     (above[g])
      );
    end
  endgenerate

  // channel outputs are already flops; the valid is delayed to match
  assign SAMPLE_O = sample_out;
  assign DETECT_O = detect;

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      SAMPLE_VALID_O <= 1'b0;
    end else begin
      SAMPLE_VALID_O <= SAMPLE_VALID_I;
    end
  end

  // ----------------------------------------------------------------
  // combined detect event
  // ----------------------------------------------------------------
  assign det_any   = |detect;
  assign event_set = det_any & armed;

  // re-arm only once every channel has dropped its detect indication
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      armed <= 1'b1;
    end else if (event_set) begin
      armed <= 1'b0;
    end else if (!det_any) begin
      armed <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // interrupt status, mask and output
  // ----------------------------------------------------------------
  assign status_clear = wr && BYTEENABLE_I[0] &&
                        idx == `SD_REG_IRQ_STAT && WRITEDATA_I[0];

  // a new event in the clearing cycle wins over the clear
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      irq_status <= 1'b0;
    end else begin
      irq_status <= event_set | (irq_status & ~status_clear);
    end
  end

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      irq_mask <= 1'b0;
    end else if (wr && BYTEENABLE_I[0] && idx == `SD_REG_IRQ_MASK) begin
      irq_mask <= WRITEDATA_I[0];
    end
  end

  // registered level; follows masked status one clock later
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= irq_status & irq_mask;
    end
  end

endmodule

// ### rtl/sigdet_cfg.svh
// constants of the input signal-detect control block
// assumes: 25 MHz clock, word-indexed 16-bit registers on a 32-bit bus
`ifndef SIGDET_CFG_SVH
`define SIGDET_CFG_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define SD_REG_IN1L      10'h312
`define SD_REG_IN1R      10'h316
`define SD_REG_IN2L      10'h31A
`define SD_REG_IN2R      10'h31E
`define SD_REG_IN3L      10'h320
`define SD_REG_IN3R      10'h326
`define SD_REG_IN4L      10'h32A
`define SD_REG_IN4R      10'h32E
`define SD_REG_GLOBAL    10'h340
`define SD_REG_IRQ_STAT  10'h350
`define SD_REG_IRQ_MASK  10'h351
`define SD_REG_STATUS    10'h352

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define SD_ENA_BIT       15
`define SD_THR_MSB       8
`define SD_THR_LSB       4
`define SD_HOLD_MSB      3
`define SD_HOLD_LSB      0
`define SD_THR_RST       5'h00
`define SD_THR_MAX       5'h0D
`define SD_HOLD_RST      4'h1
`define SD_HOLD_RSVD     4'h0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SD_STEP_MS       4
`define SD_CLK_KHZ       25000

`endif

// ### rtl/sigdet_channel.sv
// one channel of level detection, hold timing and auto-mute
// assumes: samples are two's complement, SAMPLE_W of at least 24 bits,
// and a one-cycle step pulse every 4 ms from the parent
`timescale 1ns/1ps
module sigdet_channel #(
  parameter int SAMPLE_W = 24
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   enable_i,
  input  wire logic                   valid_i,
  input  wire logic [SAMPLE_W-1:0]    sample_i,
  input  wire sigdet_pkg::thr_code_type  thr_code_i,
  input  wire sigdet_pkg::hold_code_type hold_code_i,
  input  wire logic                   step_i,
  output logic      [SAMPLE_W-1:0]    sample_o,
  output logic                        detect_o,
  output logic                        above_o
);

  // ----------------------------------------------------------------
  // lookup tables
  // ----------------------------------------------------------------
  // threshold magnitude at 24-bit full scale
  function automatic sigdet_pkg::level_type thr_level(
    input sigdet_pkg::thr_code_type code);
    case (code)
      5'h00:   thr_level = 24'h040000;
      5'h01:   thr_level = 24'h020000;
      5'h02:   thr_level = 24'h010000;
      5'h03:   thr_level = 24'h008000;
      5'h04:   thr_level = 24'h005F96;
      5'h05:   thr_level = 24'h004000;
      5'h06:   thr_level = 24'h002FE8;
      5'h07:   thr_level = 24'h002000;
      5'h08:   thr_level = 24'h001000;
      5'h09:   thr_level = 24'h000C09;
      5'h0A:   thr_level = 24'h000800;
      5'h0B:   thr_level = 24'h000608;
      5'h0C:   thr_level = 24'h000400;
      5'h0D:   thr_level = 24'h0002FD;
      default: thr_level = 24'h040000;
    endcase
  endfunction

  // hold length in whole 4 ms steps
  function automatic sigdet_pkg::hold_steps_type hold_steps(
    input sigdet_pkg::hold_code_type code);
    case (code)
      4'hB:    hold_steps = 8'h0C;
      4'hC:    hold_steps = 8'h18;
      4'hD:    hold_steps = 8'h30;
      4'hE:    hold_steps = 8'h60;
      4'hF:    hold_steps = 8'hC0;
      4'h0:    hold_steps = 8'h01;
      default: hold_steps = {4'h0, code};
    endcase
  endfunction

  // ----------------------------------------------------------------
  // level compare
  // ----------------------------------------------------------------
  logic [SAMPLE_W-1:0]      mag;
  sigdet_pkg::level_type    lvl;
  logic                     hit;
  sigdet_pkg::hold_steps_type cnt;

  // magnitude of the post-volume sample; full negative fits unsigned
  assign mag = sample_i[SAMPLE_W-1] ? (~sample_i + 1'b1) : sample_i;
  assign lvl = mag[SAMPLE_W-1 -: 24];
  assign hit = (lvl >= thr_level(thr_code_i));

  // raw above-threshold flag, seen only while enabled
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      above_o <= 1'b0;
    end else if (!enable_i) begin
      above_o <= 1'b0;
    end else if (valid_i) begin
      above_o <= hit;
    end
  end

  // ----------------------------------------------------------------
  // hold timer and detect indication
  // ----------------------------------------------------------------
  // counting one step past the code gives the documented 4 ms window
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      detect_o <= 1'b0;
      cnt      <= 8'h00;
    end else if (!enable_i) begin
      detect_o <= 1'b0;
      cnt      <= 8'h00;
    end else if (valid_i && hit) begin
      detect_o <= 1'b1;
      cnt      <= 8'h00;
    end else if (detect_o && step_i) begin
      if (cnt == hold_steps(hold_code_i)) begin
        detect_o <= 1'b0;
        cnt      <= 8'h00;
      end else begin
        cnt <= cnt + 8'h01;
      end
    end
  end

  // mute: zero unless disabled, above now, or still inside hold
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sample_o <= '0;
    end else if (valid_i) begin
      if (!enable_i || hit || detect_o) begin
        sample_o <= sample_i;
      end else begin
        sample_o <= '0;
      end
    end
  end

endmodule

// ### rtl/sigdet_pkg.sv
// types shared by the signal-detect control block
// assumes: nothing beyond standard SystemVerilog
package sigdet_pkg;
  typedef logic [4:0] thr_code_type;
  typedef logic [3:0] hold_code_type;
  typedef logic [7:0] hold_steps_type;
  typedef logic [23:0] level_type;
endpackage

// ### verification/sigdet_ctrl_sva.sv
// port checker for the signal-detect control block
// assumes: bound to input_signal_detect_ctrl, one clock, async high reset
`timescale 1ns/1ps
module sigdet_ctrl_checker #(
  parameter int SAMPLE_W    = 24,
  parameter int STEP_CYCLES = 100000
) (
  input wire logic                  MCLK_I,
  input wire logic                  RST_I,
  input wire logic                  READ_I,
  input wire logic                  WRITE_I,
  input wire logic [31:0]           READDATA_O,
  input wire logic                  WAITREQUEST_O,
  input wire logic                  SAMPLE_VALID_I,
  input wire logic [8*SAMPLE_W-1:0] SAMPLE_I,
  input wire logic                  SAMPLE_VALID_O,
  input wire logic [8*SAMPLE_W-1:0] SAMPLE_O,
  input wire logic [7:0]            DETECT_O,
  input wire logic                  IRQ_O
);
  logic wr_done;
  logic det_any;

  // helpers: a completed write, any channel detecting
  assign wr_done = WRITE_I && !WAITREQUEST_O;
  assign det_any = |DETECT_O;

  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (RST_I);

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  sequence s_one_wait;
    !WAITREQUEST_O ##1 WAITREQUEST_O;
  endsequence
  property p_wait_one;
    (READ_I || WRITE_I) && WAITREQUEST_O |=> s_one_wait;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("waitrequest not low for exactly one cycle");
  property p_wait_idle;
    !(READ_I || WRITE_I) && WAITREQUEST_O |=> WAITREQUEST_O;
  endproperty
  a_wait_idle: assert property (p_wait_idle)
    else $error("waitrequest dropped without a request");
  property p_rdata_hold;
    !(READ_I && WAITREQUEST_O) |=> $stable(READDATA_O);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed without a read");
  property p_rdata_upper;
    READDATA_O[31:16] == 16'h0000;
  endproperty
  a_rdata_upper: assert property (p_rdata_upper)
    else $error("read data upper half not zero");

  // ----------------------------------------------------------------
  // samples, detect and interrupt
  // ----------------------------------------------------------------
  property p_sample_hold;
    !SAMPLE_VALID_I |=> $stable(SAMPLE_O);
  endproperty
  a_sample_hold: assert property (p_sample_hold)
    else $error("sample output moved without a valid sample");
  // channel 0, while detecting, always passes its sample
  property p_pass_ch0;
    SAMPLE_VALID_O && DETECT_O[0] |->
      SAMPLE_O[SAMPLE_W-1:0] == $past(SAMPLE_I[SAMPLE_W-1:0]);
  endproperty
  a_pass_ch0: assert property (p_pass_ch0)
    else $error("detecting channel 0 sample not passed");
  property p_detect_cause;
    (DETECT_O & ~$past(DETECT_O)) != 8'h00 |-> $past(SAMPLE_VALID_I);
  endproperty
  a_detect_cause: assert property (p_detect_cause)
    else $error("detect rose without a sample");
  // irq rises only from a detect event or a register write
  property p_irq_rise;
    $rose(IRQ_O) |-> $past(det_any, 2) || $past(det_any, 3)
      || $past(wr_done, 2) || $past(wr_done, 3);
  endproperty
  a_irq_rise: assert property (p_irq_rise)
    else $error("interrupt rose without cause");
  property p_irq_fall;
    $fell(IRQ_O) |-> $past(wr_done, 2) || $past(wr_done, 3);
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("interrupt fell without a write");
endmodule

bind input_signal_detect_ctrl sigdet_ctrl_checker #(
  .SAMPLE_W(SAMPLE_W), .STEP_CYCLES(STEP_CYCLES)
) u_chk (
  .MCLK_I(MCLK_I), .RST_I(RST_I), .READ_I(READ_I), .WRITE_I(WRITE_I),
  .READDATA_O(READDATA_O), .WAITREQUEST_O(WAITREQUEST_O),
  .SAMPLE_VALID_I(SAMPLE_VALID_I), .SAMPLE_I(SAMPLE_I),
  .SAMPLE_VALID_O(SAMPLE_VALID_O), .SAMPLE_O(SAMPLE_O),
  .DETECT_O(DETECT_O), .IRQ_O(IRQ_O)
);

// ### verification/tb.sv
// self-checking bench for the signal-detect control block
// assumes: design and checker compiled before, STEP_CYCLES shortened to 20
`timescale 1ns/1ps
module tb;
  localparam int W = 24;
  logic         MCLK_I, RST_I, READ_I, WRITE_I, WAITREQUEST_O;
  logic         SAMPLE_VALID_I, SAMPLE_VALID_O, IRQ_O;
  logic [11:0]  ADDRESS_I;
  logic [31:0]  WRITEDATA_I, READDATA_O;
  logic [3:0]   BYTEENABLE_I;
  logic [191:0] SAMPLE_I, SAMPLE_O;
  logic [7:0]   DETECT_O;
  int           n_errors, n_compared, cycles, seed, k, j;
  logic [15:0]  rq[$];
  logic [199:0] sq[$];
  logic [9:0]   en_idx[8] = '{10'h312, 10'h316, 10'h31A, 10'h31E,
                              10'h320, 10'h326, 10'h32A, 10'h32E};

  input_signal_detect_ctrl #(.SAMPLE_W(W), .STEP_CYCLES(20)) u_dut (
    .MCLK_I(MCLK_I), .RST_I(RST_I), .ADDRESS_I(ADDRESS_I),
    .READ_I(READ_I), .WRITE_I(WRITE_I), .WRITEDATA_I(WRITEDATA_I),
    .BYTEENABLE_I(BYTEENABLE_I), .READDATA_O(READDATA_O),
    .WAITREQUEST_O(WAITREQUEST_O), .SAMPLE_VALID_I(SAMPLE_VALID_I),
    .SAMPLE_I(SAMPLE_I), .SAMPLE_VALID_O(SAMPLE_VALID_O),
    .SAMPLE_O(SAMPLE_O), .DETECT_O(DETECT_O), .IRQ_O(IRQ_O));

  // ----------------------------------------------------------------
  // checking and reporting
  // ----------------------------------------------------------------
  task automatic final_report();
    if (n_errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic note(input logic bad, input logic [199:0] g, e);
    n_compared++;
    if (bad) begin
      n_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_reg(input logic [15:0] g, e);
    note(g !== e, 200'(g), 200'(e));
  endtask
  task automatic chk_smp(input logic [199:0] g, e);
    note(g !== e, g, e);
  endtask
  task automatic chk_flag(input logic [7:0] g, e);
    note(g !== e, 200'(g), 200'(e));
  endtask

  // ----------------------------------------------------------------
  // drivers and sample helpers
  // ----------------------------------------------------------------
  // request held until waitrequest is seen low; upper lanes random
  task automatic xfer(input logic wr, input logic [9:0] idx,
                      input logic [3:0] be, input logic [15:0] d);
    @(posedge MCLK_I);
    ADDRESS_I    <= {idx, 2'b00};
    READ_I       <= !wr;
    WRITE_I      <= wr;
    WRITEDATA_I  <= {16'($random(seed)), d};
    BYTEENABLE_I <= be;
    if (!wr) rq.push_back(d);
    do @(posedge MCLK_I); while (WAITREQUEST_O !== 1'b0);
    READ_I  <= 1'b0;
    WRITE_I <= 1'b0;
  endtask
  function automatic logic [191:0] keep(input logic [191:0] s,
                                        input logic [7:0] m);
    for (int c = 0; c < 8; c++) if (!m[c]) s[c*W +: W] = '0;
    return s;
  endfunction
  // below the top threshold code by construction
  function automatic logic [191:0] quiet();
    logic [191:0] q;
    for (int c = 0; c < 8; c++) q[c*W +: W] = 24'($random(seed) % 'h3FFFF);
    return q;
  endfunction
  function automatic logic [191:0] put(input logic [191:0] q, input int c,
                                       input logic [23:0] v);
    q[c*W +: W] = v;
    return q;
  endfunction
  task automatic send(input logic [191:0] s, input logic [7:0] m, det);
    @(posedge MCLK_I);
    SAMPLE_I       <= s;
    SAMPLE_VALID_I <= 1'b1;
    sq.push_back({det, keep(s, m)});
    @(posedge MCLK_I);
    SAMPLE_VALID_I <= 1'b0;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge MCLK_I);
  endtask

  // clock, hang limit and the two result watchers
  always #20 MCLK_I = ~MCLK_I;
  always @(posedge MCLK_I) begin
    cycles++;
    if (cycles > 3000) begin
      n_errors++;
      final_report();
    end
  end
  always @(posedge MCLK_I)
    if (READ_I && WAITREQUEST_O === 1'b0)
      chk_reg(READDATA_O[15:0], rq.pop_front());
  always @(posedge MCLK_I)
    if (SAMPLE_VALID_O === 1'b1)
      chk_smp({DETECT_O, SAMPLE_O}, sq.pop_front());

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {MCLK_I, READ_I, WRITE_I, SAMPLE_VALID_I} = '0;
    {ADDRESS_I, WRITEDATA_I, BYTEENABLE_I, SAMPLE_I} = '0;
    seed = 5;
    RST_I = 1'b1;
    tick(3);
    RST_I <= 1'b0;
    for (int c = 0; c < 8; c++) xfer(0, en_idx[c], 4'hF, 16'h0000);
    xfer(0, 10'h340, 4'hF, 16'h0001);
    // enable bit needs the upper lane; unmapped word stays zero
    for (int c = 0; c < 8; c++) begin
      xfer(1, en_idx[c], 4'hF, 16'h8000);
      xfer(1, en_idx[c], 4'h1, 16'h0000);
      xfer(0, en_idx[c], 4'hF, 16'h8000);
    end
    xfer(1, 10'h313, 4'hF, 16'hFFFF);
    xfer(0, 10'h313, 4'hF, 16'h0000);
    // lowest threshold, reserved codes must leave fields alone
    xfer(1, 10'h340, 4'hF, 16'h00D3);
    xfer(1, 10'h340, 4'hF, 16'h00E3);
    xfer(1, 10'h340, 4'hF, 16'h00D0);
    xfer(0, 10'h340, 4'hF, 16'h00D3);
    send(put('0, 0, 24'h0002FC), 8'h00, 8'h00);
    send(put('0, 0, 24'h0002FD), 8'h01, 8'h01);
    // status word: above and detect both set for channel 0
    xfer(0, 10'h352, 4'hF, 16'h0101);
    tick(57);
    chk_flag(DETECT_O, 8'h01);
    tick(21);
    chk_flag(DETECT_O, 8'h00);
    chk_flag({7'h00, IRQ_O}, 8'h00);
    xfer(0, 10'h350, 4'hF, 16'h0001);
    xfer(1, 10'h350, 4'hF, 16'h0001);
    xfer(0, 10'h350, 4'hF, 16'h0000);
    // top threshold, shortest hold, interrupt unmasked
    xfer(1, 10'h340, 4'hF, 16'h0001);
    xfer(1, 10'h351, 4'hF, 16'h0001);
    k = $random(seed) & 7;
    j = (k + 1) % 8;
    send(quiet(), 8'h00, 8'h00);
    send(put(quiet(), k, 24'h040000), 8'h01 << k, 8'h01 << k);
    tick(3);
    chk_flag({7'h00, IRQ_O}, 8'h01);
    xfer(1, 10'h350, 4'hF, 16'h0001);
    // second channel while the first still holds: no new event
    send(put(quiet(), j, 24'hFC0000), (8'h01 << k) | (8'h01 << j),
         (8'h01 << k) | (8'h01 << j));
    tick(20);
    chk_flag(DETECT_O & (8'h01 << j), 8'h01 << j);
    xfer(0, 10'h350, 4'hF, 16'h0000);
    chk_flag({7'h00, IRQ_O}, 8'h00);
    tick(21);
    chk_flag(DETECT_O, 8'h00);
    send(quiet(), 8'h00, 8'h00);
    send(put(quiet(), j, 24'h040000), 8'h01 << j, 8'h01 << j);
    tick(3);
    chk_flag({7'h00, IRQ_O}, 8'h01);
    xfer(1, 10'h351, 4'hF, 16'h0000);
    tick(2);
    chk_flag({7'h00, IRQ_O}, 8'h00);
    tick(41);
    // a disabled channel passes quiet input unmuted
    xfer(1, en_idx[0], 4'hF, 16'h0000);
    send(quiet(), 8'h01, 8'h00);
    tick(3);
    // a noted result that never showed up is a mismatch too
    chk_flag(8'(rq.size() + sq.size()), 8'h00);
    final_report();
  end
endmodule
